// file: aht_pkg.sv
// package: register map, field layouts and constants of the analog threshold block
package aht_pkg;
  localparam int AHT_DATA_W = 16;
  localparam int AHT_WIDE_W = 32;
  localparam int AHT_GAIN_DIV = 100;
  localparam logic [11:0] AHT_OFF_CTRL = 12'h000;
  localparam logic [11:0] AHT_OFF_GAIN = 12'h004;
  localparam logic [11:0] AHT_OFF_OFFSET = 12'h008;
  localparam logic [11:0] AHT_OFF_ON_THR = 12'h00C;
  localparam logic [11:0] AHT_OFF_OFF_THR = 12'h010;
  localparam logic [11:0] AHT_OFF_DELTA = 12'h014;
  localparam logic [11:0] AHT_OFF_STATUS = 12'h018;
  localparam logic [11:0] AHT_OFF_DECIMALS = 12'h01C;
  localparam int AHT_CTRL_MODE_LSB = 0;
  localparam int AHT_CTRL_ENABLE_BIT = 2;
  localparam int AHT_STAT_OUT_BIT = 0;
  localparam logic [1:0] AHT_CTRL_MODE_RST = 2'h0;
  localparam logic AHT_CTRL_ENABLE_RST = 1'b1;
  localparam logic [15:0] AHT_GAIN_RST = 16'h0064;
  localparam logic [15:0] AHT_ZERO_RST = 16'h0000;
  localparam logic [1:0] AHT_DEC_RST = 2'h0;
  typedef enum logic [1:0] {
    AHT_MODE_TRIGGER,
    AHT_MODE_DIFF,
    AHT_MODE_COMPARE,
    AHT_MODE_SPARE
  } aht_mode_t;
endpackage : aht_pkg

// file: aht_scale.sv
// scaling stage: sample times gain (hundredths) plus offset
module aht_scale
  import aht_pkg::*;
#(
  parameter int DATA_W = AHT_DATA_W
) (
  input logic signed [DATA_W-1:0] sample,
  input logic signed [DATA_W-1:0] gain,
  input logic signed [DATA_W-1:0] offset,
  output logic signed [AHT_WIDE_W-1:0] value
);
  logic signed [AHT_WIDE_W-1:0] prod;
  logic signed [AHT_WIDE_W-1:0] quot;
  always_comb begin
    // gain is fixed point with two decimals, so divide after the product
    prod = AHT_WIDE_W'(sample) * AHT_WIDE_W'(gain);
    quot = prod / AHT_WIDE_W'(AHT_GAIN_DIV);
    value = quot + AHT_WIDE_W'(offset);
  end
endmodule : aht_scale

// file: aht_src.sv
// analog source model feeding the two sample inputs
module aht_src (
  input wire logic pclk,
  input wire logic signed [15:0] want_a,
  input wire logic signed [15:0] want_b,
  output logic signed [15:0] analog_in_first,
  output logic signed [15:0] analog_in_second
);
  timeunit 1ns;
  timeprecision 1ps;
  // moves only on clock edges, like a converter result register
  always_ff @(posedge pclk) begin
    analog_in_first <= want_a;
    analog_in_second <= want_b;
  end
endmodule : aht_src

// file: aht_trigger.sv
// analog threshold, differential trigger and comparator with apb registers
//
// The register offsets and the APB register port are this design's own decisions.
module aht_trigger
  import aht_pkg::*;
#(
  parameter int DATA_W = AHT_DATA_W
) (
  input logic pclk,
  input logic presetn,
  input logic clk_en,
  input logic scan_tick,
  input logic signed [DATA_W-1:0] analog_in_first,
  input logic signed [DATA_W-1:0] analog_in_second,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic trig_out
);

// Behaviour
// R1 - each input is scaled as sample times gain plus offset before any comparison.
// R2 - with on at or above off, the output sets when the scaled value exceeds on.
// R3 - with on at or above off, the output clears at or below off and otherwise holds.
// R4 - with on below off, the output is high exactly while on <= value < off.
// R5 - the decimals setting is stored for display only and never enters a comparison.
// R6 - in differential mode the off threshold is on plus the signed delta.
// R7 - a negative delta gives the hysteresis band behaviour.
// R8 - a positive delta gives the window behaviour from on up to but excluding off.
// R9 - software keeps gain within -10.00 to 10.00 in hundredths.
// R10 - software keeps the offset within -10000 to 10000.
// R11 - software keeps on and off thresholds within -20000 to 20000.
// R12 - software keeps the delta within -20000 to 20000.
// R13 - comparator mode uses two inputs and judges their difference against thresholds.
// R14 - comparator mode scales both inputs alike and subtracts the second from the first.
// R15 - evaluation happens once per scan tick into a registered bit reset low that holds.

  logic [1:0] mode_q, mode_d;
  logic enable_q, enable_d;
  logic [DATA_W-1:0] gain_q, gain_d;
  logic [DATA_W-1:0] zero_q, zero_d;
  logic [DATA_W-1:0] on_q, on_d;
  logic [DATA_W-1:0] off_q, off_d;
  logic [DATA_W-1:0] delta_q, delta_d;
  logic [1:0] dec_q, dec_d;
  logic [31:0] rdata_q, rdata_d;
  logic out_q, out_d;
  logic signed [AHT_WIDE_W-1:0] val_first;
  logic signed [AHT_WIDE_W-1:0] val_second;
  logic signed [AHT_WIDE_W-1:0] actual;
  logic signed [AHT_WIDE_W-1:0] thr_on;
  logic signed [AHT_WIDE_W-1:0] thr_off;
  logic access;
  logic mapped;

  // register offsets are checked both on write and read
  function automatic logic aht_is_mapped(input logic [11:0] a);
    case (a)
      AHT_OFF_CTRL, AHT_OFF_GAIN, AHT_OFF_OFFSET, AHT_OFF_ON_THR, AHT_OFF_OFF_THR,
      AHT_OFF_DELTA, AHT_OFF_STATUS, AHT_OFF_DECIMALS: aht_is_mapped = 1'b1;
      default: aht_is_mapped = 1'b0;
    endcase
  endfunction : aht_is_mapped

  function automatic logic [31:0] aht_sext(input logic [DATA_W-1:0] v);
    aht_sext = 32'(signed'(v));
  endfunction : aht_sext

  aht_scale #(.DATA_W(DATA_W)) u_scale_first (
    .sample(analog_in_first),
    .gain(signed'(gain_q)),
    .offset(signed'(zero_q)),
    .value(val_first)
  ); // [R1]

  aht_scale #(.DATA_W(DATA_W)) u_scale_second (
    .sample(analog_in_second),
    .gain(signed'(gain_q)),
    .offset(signed'(zero_q)),
    .value(val_second)
  ); // [R14]

  assign access = psel & penable;
  assign mapped = aht_is_mapped(paddr);
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  // error answered in the access cycle itself, the only cycle a master looks at it
  assign pslverr = access & !mapped;
  assign prdata = rdata_q;
  assign trig_out = out_q;

  always_comb begin
    mode_d = mode_q;
    enable_d = enable_q;
    gain_d = gain_q;
    zero_d = zero_q;
    on_d = on_q;
    off_d = off_q;
    delta_d = delta_q;
    dec_d = dec_q;
    rdata_d = rdata_q;
    if (psel && !penable) begin
      // read data is captured in setup so it is stable for the whole access
      rdata_d = 32'h0000_0000;
      case (paddr)
        AHT_OFF_CTRL: begin
          rdata_d[AHT_CTRL_MODE_LSB +: 2] = mode_q;
          rdata_d[AHT_CTRL_ENABLE_BIT] = enable_q;
        end
        AHT_OFF_GAIN: rdata_d = aht_sext(gain_q);
        AHT_OFF_OFFSET: rdata_d = aht_sext(zero_q);
        AHT_OFF_ON_THR: rdata_d = aht_sext(on_q);
        AHT_OFF_OFF_THR: rdata_d = aht_sext(thr_off[DATA_W-1:0]);
        AHT_OFF_DELTA: rdata_d = aht_sext(delta_q);
        AHT_OFF_STATUS: rdata_d[AHT_STAT_OUT_BIT] = out_q;
        AHT_OFF_DECIMALS: rdata_d[1:0] = dec_q; // [R5]
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (access) begin
      if (pwrite) begin
        case (paddr)
          AHT_OFF_CTRL: begin
            mode_d = pwdata[AHT_CTRL_MODE_LSB +: 2];
            enable_d = pwdata[AHT_CTRL_ENABLE_BIT];
          end
          AHT_OFF_GAIN: gain_d = pwdata[DATA_W-1:0]; // [R9]
          AHT_OFF_OFFSET: zero_d = pwdata[DATA_W-1:0]; // [R10]
          AHT_OFF_ON_THR: on_d = pwdata[DATA_W-1:0]; // [R11]
          AHT_OFF_OFF_THR: off_d = pwdata[DATA_W-1:0]; // [R11]
          AHT_OFF_DELTA: delta_d = pwdata[DATA_W-1:0]; // [R12]
          AHT_OFF_DECIMALS: dec_d = pwdata[1:0]; // [R5]
          default: begin
          end
        endcase
      end
    end
  end

  always_comb begin
    thr_on = AHT_WIDE_W'(signed'(on_q));
    thr_off = AHT_WIDE_W'(signed'(off_q));
    actual = val_first;
    case (aht_mode_t'(mode_q))
      AHT_MODE_TRIGGER: actual = val_first;
      AHT_MODE_DIFF: begin
        thr_off = thr_on + AHT_WIDE_W'(signed'(delta_q)); // [R6]
        actual = val_first;
      end
      AHT_MODE_COMPARE: actual = val_first - val_second; // [R13] [R14]
      default: actual = val_first;
    endcase
    out_d = out_q;
    if (thr_on >= thr_off) begin
      // hysteresis band, also negative delta
      if (actual > thr_on) begin
        out_d = 1'b1; // [R2] [R7]
      end else if (actual <= thr_off) begin
        out_d = 1'b0; // [R3] [R7]
      end
    end else begin
      // window, also positive delta
      out_d = (actual >= thr_on) && (actual < thr_off); // [R4] [R8]
    end
    if (!(scan_tick && enable_q)) begin
      out_d = out_q; // [R15]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= AHT_CTRL_MODE_RST;
      enable_q <= AHT_CTRL_ENABLE_RST;
      gain_q <= AHT_GAIN_RST;
      zero_q <= AHT_ZERO_RST;
      on_q <= AHT_ZERO_RST;
      off_q <= AHT_ZERO_RST;
      delta_q <= AHT_ZERO_RST;
      dec_q <= AHT_DEC_RST;
      rdata_q <= 32'h0000_0000;
      out_q <= 1'b0; // [R15]
    end else if (clk_en) begin
      mode_q <= mode_d;
      enable_q <= enable_d;
      gain_q <= gain_d;
      zero_q <= zero_d;
      on_q <= on_d;
      off_q <= off_d;
      delta_q <= delta_d;
      dec_q <= dec_d;
      rdata_q <= rdata_d;
      out_q <= out_d;
    end
  end
endmodule : aht_trigger

// file: aht_trigger_bench.sv
// self-checking bench for the analog threshold block
module aht_trigger_bench
  import aht_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int m, g, z, on, off, dl, dc, a, b, q;} aht_row_t;
  logic pclk = 0, presetn = 0, clk_en = 1, scan_tick = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, trig_out, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic signed [15:0] want_a = '0, want_b = '0, analog_in_first, analog_in_second;
  int n_errors = 0, checked = 0;
  // mode gain offset on off delta decimals a b expected; settings kept in range
  aht_row_t rows[18] = '{'{0,100,0,100,50,0,0,101,0,1},
    '{0,100,0,100,50,0,3,51,0,1}, '{0,100,0,100,50,0,0,50,0,0},
    '{0,100,0,100,50,0,0,100,0,0}, '{0,1000,10000,19999,-20000,0,0,1000,0,1},
    '{0,100,0,10,20,0,0,10,0,1}, '{0,100,0,10,20,0,2,20,0,0},
    '{0,-250,30,-20,-40,0,0,20,0,0}, '{0,-250,30,-20,-40,0,0,19,0,1},
    '{1,100,0,100,0,-30,0,71,0,1}, '{1,100,0,100,0,-30,0,70,0,0},
    '{1,100,0,100,0,-30,0,101,0,1}, '{1,100,0,100,0,30,0,130,0,0},
    '{1,100,0,100,0,30,0,100,0,1}, '{3,100,0,100,50,0,0,50,-60,0},
    '{2,10,30,15,5,0,0,1000,950,0},
    '{2,10,30,15,5,0,0,1000,840,1}, '{2,10,30,15,5,0,0,1000,900,1}};
  aht_src i_aht_src (.pclk, .want_a, .want_b, .analog_in_first, .analog_in_second);
  aht_trigger i_aht_trigger (.pclk, .presetn, .clk_en, .scan_tick, .analog_in_first,
    .analog_in_second, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .trig_out);
  always #5 pclk = ~pclk;
  task automatic give_verdict();
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, paddr, pwrite, pwdata} <= {1'h1, 1'h0, a, w, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic tick(input logic [31:0] exp);
    @(posedge pclk);
    scan_tick <= 1'h1;
    @(posedge pclk);
    scan_tick <= 1'h0;
    @(negedge pclk);
    check({31'h0, trig_out}, exp);
    // hand back just after a rising edge so callers drive on it
    @(posedge pclk);
  endtask : tick
  // every writable register rewritten per row: simpler than tracking what changed
  task automatic cfg(input aht_row_t r);
    want_a <= 16'(r.a);
    want_b <= 16'(r.b);
    apb(AHT_OFF_CTRL, 1'h1, 32'(r.m) | 32'h4);
    apb(AHT_OFF_GAIN, 1'h1, 32'(r.g));
    apb(AHT_OFF_OFFSET, 1'h1, 32'(r.z));
    apb(AHT_OFF_ON_THR, 1'h1, 32'(r.on));
    apb(AHT_OFF_OFF_THR, 1'h1, 32'(r.off));
    apb(AHT_OFF_DELTA, 1'h1, 32'(r.dl));
    apb(AHT_OFF_DECIMALS, 1'h1, 32'(r.dc));
  endtask : cfg
  initial begin
    #50us;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    apb(AHT_OFF_GAIN, 1'h0, 32'h0);
    check(rd, 32'h00000064);
    check({31'h0, err}, 32'h0);
    apb(12'h100, 1'h0, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    foreach (rows[i]) begin
      cfg(rows[i]);
      tick(32'(rows[i].q));
    end
    cfg(rows[10]);
    apb(AHT_OFF_OFF_THR, 1'h0, 32'h0);
    check(rd, 32'h00000046);
    clk_en <= 1'h0;
    tick(32'h1);
    clk_en <= 1'h1;
    tick(32'h0);
    apb(AHT_OFF_STATUS, 1'h1, 32'h1);
    apb(AHT_OFF_STATUS, 1'h0, 32'h0);
    check(rd, 32'h0);
    want_a <= 16'sh0065;
    tick(32'h1);
    presetn <= 1'h0;
    @(negedge pclk);
    check({31'h0, trig_out}, 32'h0);
    @(posedge pclk);
    presetn <= 1'h1;
    apb(AHT_OFF_CTRL, 1'h0, 32'h0);
    check(rd, 32'h00000004);
    give_verdict();
  end
endmodule : aht_trigger_bench

// file: aht_trigger_chk.sv
// port checks of the analog threshold block
module aht_trigger_chk
  import aht_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic clk_en,
  input logic scan_tick,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic trig_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  out_hold_a: assert property (!(clk_en && scan_tick) |=> $stable(trig_out))
    else $error("output moved without scan tick");
  freeze_all_a: assert property (!clk_en |=> $stable(prdata) && $stable(trig_out))
    else $error("state moved while disabled");
  reset_low_a: assert property ($rose(presetn) |-> !trig_out)
    else $error("output not low after reset");
  rise_tick_a: assert property ($rose(trig_out) |-> $past(scan_tick && clk_en))
    else $error("output set without scan tick");
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("error flag without access");
  err_unmapped_a: assert property (psel && penable && clk_en && paddr == 12'h100 |-> pslverr)
    else $error("unmapped access not flagged");
  status_mirror_a: assert property (psel && !penable && !pwrite && clk_en &&
    paddr == AHT_OFF_STATUS |=> prdata == {31'h0, $past(trig_out)}) else $error("status wrong");
  read_hold_a: assert property (psel && penable && !pwrite && clk_en |=> $stable(prdata))
    else $error("read data not held");
endmodule : aht_trigger_chk
bind aht_trigger aht_trigger_chk i_aht_trigger_chk (.pclk, .presetn, .clk_en, .scan_tick,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .trig_out);
